// ===== core/beacon_pkg.sv
// Constants shared by the ring beacon generator.
// Assumes a 200 MHz core clock and a 32-bit AHB-Lite register bus.
package beacon_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int TICK_HZ = 50_000_000;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CTRL = 8'hdc;
    localparam logic [7:0] IDX_IVL_LO = 8'hde;
    localparam logic [7:0] IDX_IVL_HI = 8'he0;
    localparam logic [7:0] IDX_TIDX = 8'he2;
    localparam logic [7:0] IDX_TVAL = 8'he4;

    // Control register fields.
    localparam int CTRL_TIMER_EN = 0;
    localparam int CTRL_GEN1 = 1;
    localparam int CTRL_GEN2 = 2;
    localparam int CTRL_GEN_RST = 3;

    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [31:0] IVL_RST = 32'h0000_0000;
    localparam logic [5:0] TIDX_RST = 6'h00;
    localparam logic [31:0] SEQ_RST = 32'h0000_0000;

    // Frame layout: 40 template bytes, sequence id big-endian.
    localparam int FRAME_LEN = 40;
    localparam logic [5:0] FRAME_END = 6'h28;
    localparam logic [5:0] FRAME_LAST = 6'h27;
    localparam logic [5:0] SEQ_POS = 6'h18;
    localparam logic [5:0] SEQ_END = 6'h1c;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } gen_state_t;
endpackage

// ===== core/ring_beacon_generator.sv
// Ring beacon generator: AHB-Lite register slave, interval timer and
// frame serializer for the two ring ports.
// Assumes one 200 MHz clock and a transmit path that accepts bytes
// on tx_valid and tx_ready.
//
// How it works
// - With timer enable set, each expiry triggers enabled ports and restarts.
// - Port one enable set: beacons go to port one with sequence id.
// - Port two enable set: beacons go to port two with sequence id.
// - Generation reset bit holds timer, sequencer and serializer in reset.
// - Interval is a 32-bit count of 50 MHz ticks.
// - Interval low register holds bits 15..0, high register bits 31..16.
// - The sequence id overrides the template at its byte positions.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ring_beacon_generator
    import beacon_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic tx_port_one,
    output logic tx_port_two
);
    logic ap_valid, addr_ok, wr_en;
    logic dp_act_q, dp_act_d;
    logic dp_wr_q, dp_wr_d;
    logic dp_ok_q, dp_ok_d;
    logic [7:0] dp_idx_q, dp_idx_d;
    logic hreadyout_q, hreadyout_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic [3:0] ctrl_q, ctrl_d;
    logic [31:0] ivl_q, ivl_d;
    logic [5:0] tidx_q, tidx_d;
    logic [7:0] tmpl [0:FRAME_LEN-1];
    logic [7:0] tval;
    logic gen_rst, timer_en, tick, expire, rearm, fire;
    logic [31:0] rd_val, cnt_nxt;
    logic [1:0] pre_q, pre_d;
    logic [31:0] cnt_q, cnt_d;
    logic en_prev_q, en_prev_d;
    logic pend_q, pend_d;
    gen_state_t state_q, state_d;
    logic [5:0] pos_q, pos_d, pos_nxt;
    logic [31:0] seq_q, seq_d;
    logic tx_valid_q, tx_valid_d;
    logic [7:0] tx_data_q, tx_data_d;
    logic tx_last_q, tx_last_d;
    logic p1_q, p1_d, p2_q, p2_d;

    // Sequence bytes replace the template, most significant first.
    function automatic logic [7:0] frame_byte(
        input logic [5:0] p,
        input logic [7:0] t,
        input logic [31:0] s
    );
        logic [5:0] o;
        o = p - SEQ_POS;
        frame_byte = t;
        if (p >= SEQ_POS && p < SEQ_END) begin
            unique case (o[1:0])
                2'h0: frame_byte = s[31:24];
                2'h1: frame_byte = s[23:16];
                2'h2: frame_byte = s[15:8];
                2'h3: frame_byte = s[7:0];
            endcase
        end
    endfunction

    assign ap_valid = hsel && hready && htrans[1];
    assign addr_ok = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
    assign wr_en = dp_act_q && dp_wr_q && dp_ok_q && hreadyout_q;
    assign tval = (tidx_q < FRAME_END) ? tmpl[tidx_q] : 8'h00;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (dp_ok_q) begin
            unique case (dp_idx_q)
                IDX_CTRL: rd_val = {28'h000_0000, ctrl_q};
                IDX_IVL_LO: rd_val = {16'h0000, ivl_q[15:0]};
                IDX_IVL_HI: rd_val = {16'h0000, ivl_q[31:16]};
                IDX_TIDX: rd_val = {26'h000_0000, tidx_q};
                IDX_TVAL: rd_val = {24'h00_0000, tval};
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    // Reads take one wait state so a write just before is always seen.
    always_comb begin
        dp_act_d = dp_act_q;
        dp_wr_d = dp_wr_q;
        dp_ok_d = dp_ok_q;
        dp_idx_d = dp_idx_q;
        hreadyout_d = 1'b1;
        hrdata_d = hrdata_q;
        if (hready) begin
            dp_act_d = ap_valid;
            dp_wr_d = hwrite;
            dp_ok_d = addr_ok;
            dp_idx_d = haddr[9:2];
        end
        if (ap_valid && !hwrite) begin
            hreadyout_d = 1'b0;
        end
        if (dp_act_q && !dp_wr_q && !hreadyout_q) begin
            hrdata_d = rd_val;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dp_act_q <= 1'b0;
            dp_wr_q <= 1'b0;
            dp_ok_q <= 1'b0;
            dp_idx_q <= 8'h00;
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
        end else begin
            dp_act_q <= dp_act_d;
            dp_wr_q <= dp_wr_d;
            dp_ok_q <= dp_ok_d;
            dp_idx_q <= dp_idx_d;
            hreadyout_q <= hreadyout_d;
            hrdata_q <= hrdata_d;
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        ivl_d = ivl_q;
        tidx_d = tidx_q;
        if (wr_en) begin
            unique case (dp_idx_q)
                IDX_CTRL: ctrl_d = hwdata[3:0];
                IDX_IVL_LO: ivl_d[15:0] = hwdata[15:0];
                IDX_IVL_HI: ivl_d[31:16] = hwdata[15:0];
                IDX_TIDX: tidx_d = hwdata[5:0];
                default: ctrl_d = ctrl_q;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            ivl_q <= IVL_RST;
            tidx_q <= TIDX_RST;
        end else begin
            ctrl_q <= ctrl_d;
            ivl_q <= ivl_d;
            tidx_q <= tidx_d;
        end
    end

    // Template has no reset; software fills it before use.
    always_ff @(posedge clock) begin
        if (wr_en && dp_idx_q == IDX_TVAL && tidx_q < FRAME_END) begin
            tmpl[tidx_q] <= hwdata[7:0];
        end
    end

    assign gen_rst = ctrl_q[CTRL_GEN_RST];
    assign timer_en = ctrl_q[CTRL_TIMER_EN];
    assign tick = (pre_q == TICK_LAST);
    assign cnt_nxt = cnt_q + 32'h0000_0001;
    assign expire = timer_en && tick && (cnt_nxt >= ivl_q);
    assign rearm = timer_en && !en_prev_q;
    assign fire = (expire || rearm) &&
        (ctrl_q[CTRL_GEN1] || ctrl_q[CTRL_GEN2]);
    assign pos_nxt = pos_q + 6'h01;

    always_comb begin
        pre_d = pre_q + 2'h1;
        cnt_d = cnt_q;
        en_prev_d = timer_en;
        pend_d = pend_q || fire;
        state_d = state_q;
        pos_d = pos_q;
        seq_d = seq_q;
        tx_valid_d = tx_valid_q;
        tx_data_d = tx_data_q;
        tx_last_d = tx_last_q;
        p1_d = p1_q;
        p2_d = p2_q;
        if (!timer_en) begin
            pre_d = 2'h0;
            cnt_d = 32'h0000_0000;
        end else if (tick) begin
            pre_d = 2'h0;
            cnt_d = expire ? 32'h0000_0000 : cnt_nxt;
        end
        unique case (state_q)
            ST_IDLE: begin
                if (pend_q) begin
                    pend_d = fire;
                    p1_d = ctrl_q[CTRL_GEN1];
                    p2_d = ctrl_q[CTRL_GEN2];
                    if (ctrl_q[CTRL_GEN1] || ctrl_q[CTRL_GEN2]) begin
                        state_d = ST_SEND;
                        pos_d = 6'h00;
                        tx_valid_d = 1'b1;
                        tx_last_d = 1'b0;
                        tx_data_d = frame_byte(6'h00, tmpl[0], seq_q);
                    end
                end
            end
            ST_SEND: begin
                if (tx_ready) begin
                    if (tx_last_q) begin
                        state_d = ST_IDLE;
                        tx_valid_d = 1'b0;
                        tx_last_d = 1'b0;
                        seq_d = seq_q + 32'h0000_0001;
                    end else begin
                        pos_d = pos_nxt;
                        tx_last_d = (pos_nxt == FRAME_LAST);
                        tx_data_d = frame_byte(pos_nxt, tmpl[pos_nxt],
                            seq_q);
                    end
                end
            end
        endcase
        if (gen_rst) begin
            pre_d = 2'h0;
            cnt_d = 32'h0000_0000;
            en_prev_d = 1'b0;
            pend_d = 1'b0;
            state_d = ST_IDLE;
            pos_d = 6'h00;
            seq_d = SEQ_RST;
            tx_valid_d = 1'b0;
            tx_data_d = 8'h00;
            tx_last_d = 1'b0;
            p1_d = 1'b0;
            p2_d = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pre_q <= 2'h0;
            cnt_q <= 32'h0000_0000;
            en_prev_q <= 1'b0;
            pend_q <= 1'b0;
            state_q <= ST_IDLE;
            pos_q <= 6'h00;
            seq_q <= SEQ_RST;
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
            tx_last_q <= 1'b0;
            p1_q <= 1'b0;
            p2_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            en_prev_q <= en_prev_d;
            pend_q <= pend_d;
            state_q <= state_d;
            pos_q <= pos_d;
            seq_q <= seq_d;
            tx_valid_q <= tx_valid_d;
            tx_data_q <= tx_data_d;
            tx_last_q <= tx_last_d;
            p1_q <= p1_d;
            p2_q <= p2_d;
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;
    assign tx_valid = tx_valid_q;
    assign tx_data = tx_data_q;
    assign tx_last = tx_last_q;
    assign tx_port_one = p1_q;
    assign tx_port_two = p2_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_read_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    a_read_wait: assert property (ap_valid && !hwrite |=> s_read_wait)
        else $error("read did not take exactly one wait state");
    a_ivl_split: assert property (wr_en && dp_idx_q == IDX_IVL_LO |=>
        ivl_q[15:0] == $past(hwdata[15:0]) &&
        ivl_q[31:16] == $past(ivl_q[31:16]))
        else $error("interval low write disturbed wrong half");
    a_gen_reset: assert property (gen_rst |=> !tx_valid && seq_q == 0)
        else $error("generation reset did not hold logic");
    a_expire_restart: assert property (expire && fire && !gen_rst |=>
        cnt_q == 0 && pend_q)
        else $error("expiry did not restart timer and trigger");
    a_tick_gap: assert property (tick |=> !tick [*3])
        else $error("tick came sooner than four cycles");
    a_tick_rate: assert property (tick && timer_en && !gen_rst ##1
        (timer_en && !gen_rst) [*3] |=> tick)
        else $error("tick cadence is not one in four cycles");
    a_rearm_fire: assert property (rearm && !gen_rst &&
        ctrl_q[CTRL_GEN1] && state_q == ST_IDLE ##1 !gen_rst |=>
        tx_valid)
        else $error("re-enable did not start a beacon");
    a_port_one: assert property ($rose(tx_valid) |->
        tx_port_one == $past(ctrl_q[CTRL_GEN1]))
        else $error("port one select mismatch");
    a_port_two: assert property ($rose(tx_valid) |->
        tx_port_two == $past(ctrl_q[CTRL_GEN2]))
        else $error("port two select mismatch");
    a_seq_insert: assert property (tx_valid && pos_q == SEQ_POS |->
        tx_data == seq_q[31:24])
        else $error("sequence id missing from frame");
    a_seq_advance: assert property (tx_valid && tx_ready && tx_last &&
        !gen_rst |=> seq_q == $past(seq_q) + 32'h0000_0001)
        else $error("sequence id did not advance by one");
endmodule
`default_nettype wire

// ===== testbench/ring_beacon_generator_tb_top.sv
// Self-checking bench for the ring beacon generator.
// Assumes the generator alone on an AHB-Lite bus with hready tied back.
`timescale 1ns/1ps
`default_nettype none
module ring_beacon_generator_tb_top;
    import beacon_pkg::*;
    logic clock, rst, hsel, hwrite, tx_ready;
    logic [31:0] haddr, hwdata, seq_exp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hreadyout, hresp, tx_valid, tx_last, tx_port_one, tx_port_two;
    wire logic [31:0] hrdata;
    wire logic [7:0] tx_data;
    int errors, comparisons, cycles;

    ring_beacon_generator i_ring_beacon_generator (
        .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_port_one(tx_port_one),
        .tx_port_two(tx_port_two)
    );

    always #2.5 clock = ~clock;

    // The ceiling is over twenty times the longest expected run.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("wrong value at %0t: run timed out", $time);
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time,
                     what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp,
                           input string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask

    function automatic logic [7:0] tb_byte(input int i);
        return 8'(i * 7 + 32'h0000_003c);
    endfunction

    // Registers sit on word addresses four times their index.
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk_bit(hresp, 1'b0, "okay response");
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        bus(1'b1, idx, wd, rd);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 32'h0, rd);
        chk_word(rd, exp, "register read");
    endtask

    // Receives one frame; a stalled receiver drops tx_ready every other cycle.
    task automatic get_frame(input logic stall, input logic p1,
                             input logic p2, output int start);
        int n;
        int k;
        logic [7:0] e;
        n = 0;
        k = 0;
        start = -1;
        while (n < FRAME_LEN && k < 600) begin
            @(posedge clock);
            k++;
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                if (n == 0) begin
                    start = cycles;
                end
                e = tb_byte(n);
                if (n >= int'(SEQ_POS) && n < int'(SEQ_END)) begin
                    e = seq_exp[8 * (int'(SEQ_END) - 1 - n) +: 8];
                end
                chk_word({24'h0, tx_data}, {24'h0, e}, "byte");
                chk_bit(tx_last, n == FRAME_LEN - 1, "last");
                chk_bit(tx_port_one, p1, "port one");
                chk_bit(tx_port_two, p2, "port two");
                n++;
            end
            tx_ready <= (stall && n < FRAME_LEN) ? k[0] : 1'b1;
        end
        chk_bit(n == FRAME_LEN, 1'b1, "frame length");
        seq_exp++;
    endtask

    // Re-enabling the timer must start a frame within a few cycles.
    task automatic trig_frame(input logic [31:0] ctrl, input logic stall,
                              input logic p1, input logic p2);
        int t0;
        int s;
        wr(IDX_CTRL, 32'h0);
        wr(IDX_CTRL, ctrl);
        t0 = cycles;
        get_frame(stall, p1, p2, s);
        chk_bit(s >= 0 && s - t0 <= 8, 1'b1, "immediate start");
    endtask

    task automatic period_case();
        int s1;
        int s2;
        wr(IDX_CTRL, 32'h0);
        wr(IDX_IVL_HI, 32'h0);
        wr(IDX_IVL_LO, 32'h0000_0014);
        trig_frame(32'h0000_0003, 1'b0, 1'b1, 1'b0);
        get_frame(1'b0, 1'b1, 1'b0, s1);
        get_frame(1'b0, 1'b1, 1'b0, s2);
        chk_word(32'(s2 - s1), 32'(20 * TICK_DIV), "period");
    endtask

    task automatic gen_reset_case();
        int k;
        k = 0;
        while (tx_valid !== 1'b1 && k < 200) begin
            @(posedge clock);
            k++;
        end
        chk_bit(tx_valid, 1'b1, "frame before reset");
        wr(IDX_CTRL, 32'h0000_000b);
        repeat (3) @(posedge clock);
        for (k = 0; k < 20; k++) begin
            @(posedge clock);
            chk_bit(tx_valid, 1'b0, "held in reset");
        end
        seq_exp = 32'h0;
        trig_frame(32'h0000_0003, 1'b0, 1'b1, 1'b0);
    endtask

    initial begin
        int i;
        clock = 1'b0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        tx_ready = 1'b1;
        seq_exp = 32'h0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rd_chk(IDX_CTRL, 32'h0);
        rd_chk(IDX_IVL_LO, 32'h0);
        rd_chk(IDX_IVL_HI, 32'h0);
        rd_chk(IDX_TIDX, 32'h0);
        wr(8'h10, 32'h0000_00ff);
        rd_chk(8'h10, 32'h0);
        wr(IDX_IVL_LO, 32'h0000_beef);
        wr(IDX_IVL_HI, 32'h0000_0001);
        rd_chk(IDX_IVL_LO, 32'h0000_beef);
        rd_chk(IDX_IVL_HI, 32'h0000_0001);
        for (i = 0; i < FRAME_LEN; i++) begin
            wr(IDX_TIDX, 32'(i));
            wr(IDX_TVAL, {24'h0, tb_byte(i)});
        end
        wr(IDX_TIDX, 32'h0000_0005);
        rd_chk(IDX_TVAL, {24'h0, tb_byte(5)});
        wr(IDX_TIDX, 32'h0000_0027);
        rd_chk(IDX_TVAL, {24'h0, tb_byte(39)});
        wr(IDX_TIDX, 32'h0000_0028);
        wr(IDX_TVAL, 32'h0000_005a);
        rd_chk(IDX_TVAL, 32'h0);
        trig_frame(32'h0000_0003, 1'b0, 1'b1, 1'b0);
        trig_frame(32'h0000_0005, 1'b1, 1'b0, 1'b1);
        trig_frame(32'h0000_0007, 1'b1, 1'b1, 1'b1);
        period_case();
        gen_reset_case();
        give_verdict();
    end
endmodule
`default_nettype wire
